// ---- rtl/cipc_defines.vh ----
// Register offsets, field positions, reset values and gain constants for the input path control
`ifndef CIPC_DEFINES_VH
`define CIPC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register addresses (7-bit control word address)
// ----------------------------------------------------------------------------
`define CIPC_ADDR_W            7
`define CIPC_DATA_W            9
`define CIPC_ADDR_LEFT_LINE    7'h00
`define CIPC_ADDR_RIGHT_LINE   7'h01
`define CIPC_ADDR_MIC_PATH     7'h04

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CIPC_GAIN_W            5
`define CIPC_GAIN_MSB          4
`define CIPC_GAIN_LSB          0
`define CIPC_SILENCE_BIT       7
`define CIPC_COPY_BIT          8
`define CIPC_MIC_BOOST_BIT     0
`define CIPC_MIC_SILENCE_BIT   1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CIPC_GAIN_RESET        5'h17
`define CIPC_SILENCE_RESET     1'h1
`define CIPC_COPY_RESET        1'h0
`define CIPC_MIC_BOOST_RESET   1'h0
`define CIPC_MIC_SILENCE_RESET 1'h1

// ----------------------------------------------------------------------------
// Gain arithmetic in half-dB units (signed 8 bit)
// ----------------------------------------------------------------------------
`define CIPC_HDB_W             8
`define CIPC_LINE_OFFSET_HDB   8'h45
`define CIPC_LINE_HDB_RESET    8'h00
`define CIPC_MIC_BOOST_HDB     8'h28
`define CIPC_MIC_FLAT_HDB      8'h00

`endif

// ---- rtl/cipc_gain_map.v ----
// Line-input gain code to signed half-dB converter, registered
`timescale 1ns/1ps
`default_nettype none
`include "cipc_defines.vh"

module cipc_gain_map
(
   // Clock and reset
   input  wire                        clk,
   input  wire                        rst_n,
   // Gain code in, half-dB gain out
   input  wire [`CIPC_GAIN_W-1:0]     gain_code,
   output reg  [`CIPC_HDB_W-1:0]      gain_hdb
);

   // ----------------------------------------------------------------------------
   // Mapping: code*3 half-dB minus 69, so 11111 is +24 (+12 dB), 00000 is -69
   // ----------------------------------------------------------------------------
   wire [`CIPC_HDB_W-1:0] next_gain_hdb;

   // Times three as code plus twice code, then remove the bottom offset
   assign next_gain_hdb = ({3'h0, gain_code} + {2'h0, gain_code, 1'b0})
                          - `CIPC_LINE_OFFSET_HDB;

   // Output register
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         gain_hdb <= `CIPC_LINE_HDB_RESET;
      else
         gain_hdb <= next_gain_hdb;
   end

endmodule // cipc_gain_map
`default_nettype wire

// ---- rtl/cipc_input_path.v ----
// Record-input control registers: line gains, line silences, copy loads, mic boost and silence
`timescale 1ns/1ps
`default_nettype none
`include "cipc_defines.vh"

module cipc_input_path
(
   // Clock and reset
   input  wire                        clk,
   input  wire                        rst_n,
   // Completed control writes from the serial control port
   input  wire                        wr_strobe,
   input  wire [`CIPC_ADDR_W-1:0]     wr_addr,
   input  wire [`CIPC_DATA_W-1:0]     wr_data,
   // Register readback
   input  wire [`CIPC_ADDR_W-1:0]     rd_addr,
   output reg  [`CIPC_DATA_W-1:0]     rd_data,
   // Line input settings
   output reg  [`CIPC_GAIN_W-1:0]     left_line_gain,
   output reg  [`CIPC_GAIN_W-1:0]     right_line_gain,
   output reg                         left_line_adc_silence,
   output reg                         right_line_adc_silence,
   output wire [`CIPC_HDB_W-1:0]      left_line_gain_hdb,
   output wire [`CIPC_HDB_W-1:0]      right_line_gain_hdb,
   // ADC feed enables (bypass path is never gated here)
   output reg                         left_line_adc_feed,
   output reg                         right_line_adc_feed,
   output reg                         mic_adc_feed,
   // Microphone settings
   output reg                         mic_extra_gain,
   output reg                         mic_adc_silence,
   output reg  [`CIPC_HDB_W-1:0]      mic_stage2_hdb
);

   // ----------------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------------
   reg                       left_to_right_copy;
   reg                       right_to_left_copy;
   wire                      wr_left;
   wire                      wr_right;
   wire                      wr_mic;
   wire                      copy_req;
   wire [`CIPC_GAIN_W-1:0]   wr_gain;
   wire                      wr_silence;

   // Address match for each register; any other address is dropped
   // One strobe carries one address, so a channel's own write and a copy
   // load from the other channel can never land in the same clock
   assign wr_left    = wr_strobe && (wr_addr == `CIPC_ADDR_LEFT_LINE);
   assign wr_right   = wr_strobe && (wr_addr == `CIPC_ADDR_RIGHT_LINE);
   assign wr_mic     = wr_strobe && (wr_addr == `CIPC_ADDR_MIC_PATH);
   assign copy_req   = wr_data[`CIPC_COPY_BIT];
   assign wr_gain    = wr_data[`CIPC_GAIN_MSB:`CIPC_GAIN_LSB];
   assign wr_silence = wr_data[`CIPC_SILENCE_BIT];

   // ----------------------------------------------------------------------------
   // Left line register
   // ----------------------------------------------------------------------------
   // Loaded by its own write, or by a right write with the copy bit set
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         left_line_gain        <= `CIPC_GAIN_RESET;
         left_line_adc_silence <= `CIPC_SILENCE_RESET;
         left_to_right_copy    <= `CIPC_COPY_RESET;
      end
      else if (wr_left)
      begin
         left_line_gain        <= wr_gain;
         left_line_adc_silence <= wr_silence;
         left_to_right_copy    <= copy_req;
      end
      else if (wr_right && copy_req)
      begin
         left_line_gain        <= wr_gain;
         left_line_adc_silence <= wr_silence;
      end
   end

   // ----------------------------------------------------------------------------
   // Right line register
   // ----------------------------------------------------------------------------
   // Loaded by its own write, or by a left write with the copy bit set
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         right_line_gain        <= `CIPC_GAIN_RESET;
         right_line_adc_silence <= `CIPC_SILENCE_RESET;
         right_to_left_copy     <= `CIPC_COPY_RESET;
      end
      else if (wr_right)
      begin
         right_line_gain        <= wr_gain;
         right_line_adc_silence <= wr_silence;
         right_to_left_copy     <= copy_req;
      end
      else if (wr_left && copy_req)
      begin
         right_line_gain        <= wr_gain;
         right_line_adc_silence <= wr_silence;
      end
   end

   // ----------------------------------------------------------------------------
   // Microphone register
   // ----------------------------------------------------------------------------
   // Only boost and silence live here; the other bits of this word are dropped
   // Bypass and sidetone routing stay outside, so silencing here never cuts them
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mic_extra_gain  <= `CIPC_MIC_BOOST_RESET;
         mic_adc_silence <= `CIPC_MIC_SILENCE_RESET;
      end
      else if (wr_mic)
      begin
         mic_extra_gain  <= wr_data[`CIPC_MIC_BOOST_BIT];
         mic_adc_silence <= wr_data[`CIPC_MIC_SILENCE_BIT];
      end
   end

   // ----------------------------------------------------------------------------
   // Derived analog controls
   // ----------------------------------------------------------------------------
   // ADC feeds follow the silence bits one clock later; bypass and sidetone untouched
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         left_line_adc_feed  <= 1'h0;
         right_line_adc_feed <= 1'h0;
         mic_adc_feed        <= 1'h0;
         mic_stage2_hdb      <= `CIPC_MIC_FLAT_HDB;
      end
      else
      begin
         left_line_adc_feed  <= ~left_line_adc_silence;
         right_line_adc_feed <= ~right_line_adc_silence;
         mic_adc_feed        <= ~mic_adc_silence;
         mic_stage2_hdb      <= mic_extra_gain ? `CIPC_MIC_BOOST_HDB
                                               : `CIPC_MIC_FLAT_HDB;
      end
   end

   // Gain code to half-dB for each line channel
   cipc_gain_map u_left_map
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .gain_code (left_line_gain),
      .gain_hdb  (left_line_gain_hdb)
   );

   cipc_gain_map u_right_map
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .gain_code (right_line_gain),
      .gain_hdb  (right_line_gain_hdb)
   );

   // ----------------------------------------------------------------------------
   // Readback
   // ----------------------------------------------------------------------------
   reg [`CIPC_DATA_W-1:0] next_rd_data;

   // Undefined bits and unmapped addresses read as zero
   always @*
   begin
      next_rd_data = {`CIPC_DATA_W{1'b0}};
      case (rd_addr)
         `CIPC_ADDR_LEFT_LINE:
         begin
            next_rd_data[`CIPC_GAIN_MSB:`CIPC_GAIN_LSB] = left_line_gain;
            next_rd_data[`CIPC_SILENCE_BIT]             = left_line_adc_silence;
            next_rd_data[`CIPC_COPY_BIT]                = left_to_right_copy;
         end
         `CIPC_ADDR_RIGHT_LINE:
         begin
            next_rd_data[`CIPC_GAIN_MSB:`CIPC_GAIN_LSB] = right_line_gain;
            next_rd_data[`CIPC_SILENCE_BIT]             = right_line_adc_silence;
            next_rd_data[`CIPC_COPY_BIT]                = right_to_left_copy;
         end
         `CIPC_ADDR_MIC_PATH:
         begin
            next_rd_data[`CIPC_MIC_BOOST_BIT]   = mic_extra_gain;
            next_rd_data[`CIPC_MIC_SILENCE_BIT] = mic_adc_silence;
         end
         default:
         begin
            next_rd_data = {`CIPC_DATA_W{1'b0}};
         end
      endcase
   end

   // Registered read data; a read in the write's own clock returns the old value
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= {`CIPC_DATA_W{1'b0}};
      else
         rd_data <= next_rd_data;
   end

endmodule // cipc_input_path
`default_nettype wire

// ---- sim/cipc_input_path_chk.sv ----
// Concurrent checks on the input path control register ports
`timescale 1ns/1ps
`default_nettype none
module cipc_input_path_chk
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Write and read port
   input wire logic       wr_strobe,
   input wire logic [6:0] wr_addr,
   input wire logic [8:0] wr_data,
   input wire logic [6:0] rd_addr,
   input wire logic [8:0] rd_data,
   // Settings
   input wire logic [4:0] left_line_gain,
   input wire logic [4:0] right_line_gain,
   input wire logic       left_line_adc_silence,
   input wire logic       right_line_adc_silence,
   input wire logic [7:0] left_line_gain_hdb,
   input wire logic       left_line_adc_feed,
   input wire logic       mic_extra_gain,
   input wire logic       mic_adc_silence,
   input wire logic [7:0] mic_stage2_hdb
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Decoded write strobes
   wire logic wl = wr_strobe && wr_addr == 7'h00;
   wire logic wr = wr_strobe && wr_addr == 7'h01;
   wire logic wm = wr_strobe && wr_addr == 7'h04;
   wire logic wu = wr_strobe && !wl && !wr && !wm;
   AST_LEFT_WRITE: assert property (wl |=> left_line_gain == $past(wr_data[4:0])
      && left_line_adc_silence == $past(wr_data[7])) else $error("left write not applied");
   AST_LEFT_COPY: assert property (wl && wr_data[8] |=> right_line_gain == $past(wr_data[4:0])
      && right_line_adc_silence == $past(wr_data[7])) else $error("left copy not applied");
   AST_RIGHT_COPY: assert property (wr && wr_data[8] |=> left_line_gain == $past(wr_data[4:0])
      && left_line_adc_silence == $past(wr_data[7])) else $error("right copy not applied");
   AST_RIGHT_ALONE: assert property (wr && !wr_data[8] |=> $stable(left_line_gain))
      else $error("left changed without copy");
   AST_MIC_WRITE: assert property (wm |=> mic_extra_gain == $past(wr_data[0])
      && mic_adc_silence == $past(wr_data[1])) else $error("mic write not applied");
   AST_GAIN_MAP: assert property (1'b1 |=>
      left_line_gain_hdb == $past(left_line_gain) * 8'h03 - 8'h45) else $error("gain map wrong");
   AST_FEED: assert property (1'b1 |=> left_line_adc_feed == !$past(left_line_adc_silence))
      else $error("feed not the inverse of silence");
   AST_BOOST: assert property (1'b1 |=> mic_stage2_hdb == ($past(mic_extra_gain) ? 8'h28 : 8'h00))
      else $error("boost gain wrong");
   AST_UNMAPPED: assert property (wu |=> $stable(left_line_gain) && $stable(mic_extra_gain))
      else $error("unmapped write changed state");
   AST_MIC_READ: assert property (rd_addr == 7'h04 |=> rd_data ==
      {7'h00, $past(mic_adc_silence), $past(mic_extra_gain)}) else $error("mic readback wrong");
endmodule // cipc_input_path_chk
bind cipc_input_path cipc_input_path_chk u_chk (.clk(clk), .rst_n(rst_n), .wr_strobe(wr_strobe),
   .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
   .left_line_gain(left_line_gain), .right_line_gain(right_line_gain),
   .left_line_adc_silence(left_line_adc_silence), .right_line_adc_silence(right_line_adc_silence),
   .left_line_gain_hdb(left_line_gain_hdb), .left_line_adc_feed(left_line_adc_feed),
   .mic_extra_gain(mic_extra_gain), .mic_adc_silence(mic_adc_silence),
   .mic_stage2_hdb(mic_stage2_hdb));
`default_nettype wire

// ---- sim/cipc_host_model.sv ----
// Host side model that issues completed control writes and readback requests
`timescale 1ns/1ps
`default_nettype none
module cipc_host_model
(
   // Clock
   input  wire logic       clk,
   // Write and read requests
   output logic            wr_strobe,
   output logic [6:0]      wr_addr,
   output logic [8:0]      wr_data,
   output logic [6:0]      rd_addr
);
   // Idle values from time zero
   initial
   begin
      wr_strobe = 1'b0;
      wr_addr = 7'h7F;
      wr_data = 9'h1FF;
      rd_addr = 7'h00;
   end
   // One completed write, then the bus shows junk so stale values cannot pass
   task write_reg(input logic [6:0] a, input logic [8:0] d);
      @(posedge clk);
      wr_strobe <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_strobe <= 1'b0;
      wr_addr <= ~a;
      wr_data <= ~d;
   endtask
   // Readback: address, sampling edge, then settled data
   task read_reg(input logic [6:0] a);
      @(posedge clk);
      rd_addr <= a;
      @(posedge clk);
      @(posedge clk);
      #1;
   endtask
endmodule // cipc_host_model
`default_nettype wire

// ---- sim/cipc_input_path_tb_top.sv ----
// Self-checking testbench for the input path control registers
`timescale 1ns/1ps
`default_nettype none
module cipc_input_path_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, wr_strobe, lfeed, rfeed, mfeed;
   logic lsil, rsil, msil, mboost;
   logic [4:0] lgain, rgain;
   logic [6:0] wr_addr, rd_addr;
   logic [8:0] wr_data, rd_data;
   logic [7:0] lhdb, rhdb, m2;
   int fail_count = 0, samples_checked = 0;
   // Clock of 10 ns
   always #5 clk = ~clk;
   cipc_host_model u_host (.clk(clk), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr));
   cipc_input_path u_dut (.clk(clk), .rst_n(rst_n), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .left_line_gain(lgain),
      .right_line_gain(rgain), .left_line_adc_silence(lsil), .right_line_adc_silence(rsil),
      .left_line_gain_hdb(lhdb), .right_line_gain_hdb(rhdb), .left_line_adc_feed(lfeed),
      .right_line_adc_feed(rfeed), .mic_adc_feed(mfeed), .mic_extra_gain(mboost),
      .mic_adc_silence(msil), .mic_stage2_hdb(m2));
   // Compare one result
   task check(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task finish_test;
      $display("checked=%0d failed=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Reset values through readback and derived outputs
   task t_reset;
      u_host.read_reg(7'h00); check(rd_data, 9'h097);
      u_host.read_reg(7'h01); check(rd_data, 9'h097);
      check({1'b0, lhdb}, 9'h000);
      check({lsil, rsil, msil, mboost, lgain}, 9'h1D7);
      check({4'h0, rgain}, 9'h017);
      u_host.read_reg(7'h04); check(rd_data, 9'h002);
      check({lfeed, rfeed, mfeed, 6'h00}, 9'h000);
   endtask
   // Left write with copy, top gain code
   task t_copy_left;
      u_host.write_reg(7'h00, 9'h11F);
      u_host.read_reg(7'h00); check(rd_data, 9'h11F);
      u_host.read_reg(7'h01); check(rd_data, 9'h01F);
      check({1'b0, rhdb}, 9'h018);
      check({lsil, rsil, 2'h0, rgain}, 9'h01F);
   endtask
   // Right write with copy, bottom gain code, unmuted
   task t_copy_right;
      u_host.write_reg(7'h01, 9'h100);
      u_host.read_reg(7'h00); check(rd_data, 9'h100);
      check({1'b0, lhdb}, 9'h0BB);
      check({lsil, rsil, 2'h0, lgain}, 9'h000);
      check({7'h00, lfeed, rfeed}, 9'h003);
   endtask
   // Left then right write without copy, undefined bits set
   task t_no_copy;
      u_host.write_reg(7'h00, 9'h07F);
      u_host.read_reg(7'h00); check(rd_data, 9'h01F);
      u_host.read_reg(7'h01); check(rd_data, 9'h100);
      u_host.write_reg(7'h01, 9'h0AA);
      u_host.read_reg(7'h01); check(rd_data, 9'h08A);
      u_host.read_reg(7'h00); check(rd_data, 9'h01F);
      check({1'b0, rhdb}, 9'h0D9);
      check({7'h00, lfeed, rfeed}, 9'h002);
   endtask
   // Microphone boost and silence, both polarities
   task t_mic;
      u_host.write_reg(7'h04, 9'h1FD);
      u_host.read_reg(7'h04); check(rd_data, 9'h001);
      check({mfeed, m2}, 9'h128);
      check({7'h00, msil, mboost}, 9'h001);
      u_host.write_reg(7'h04, 9'h002);
      u_host.read_reg(7'h04); check(rd_data, 9'h002);
      check({mfeed, m2}, 9'h000);
      check({7'h00, msil, mboost}, 9'h002);
   endtask
   // Write to an unmapped address is ignored
   task t_unmapped;
      u_host.write_reg(7'h02, 9'h1FF);
      u_host.read_reg(7'h02); check(rd_data, 9'h000);
      u_host.read_reg(7'h04); check(rd_data, 9'h002);
   endtask
   // Reset in mid-run brings every setting back to its reset value
   task t_rereset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      u_host.read_reg(7'h01); check(rd_data, 9'h097);
      check({lsil, rsil, msil, mboost, lgain}, 9'h1D7);
      check({lfeed, rfeed, mfeed, 6'h00}, 9'h000);
      check({1'b0, lhdb}, 9'h000);
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_copy_left;
      t_copy_right;
      t_no_copy;
      t_mic;
      t_unmapped;
      t_rereset;
      finish_test;
   end
   // Watchdog
   initial
   begin
      #20000;
      fail_count++;
      finish_test;
   end
endmodule // cipc_input_path_tb_top
`default_nettype wire
